/* tsop_top.sv */
// Operation
// - reset pin low holds all logic in reset
// - packet start flag high only on first byte of each packet
// - byte valid flag high only in byte slots carrying a valid byte
// - eight bit byte bus, tri-stated by a control register bit
// - stream byte clock runs at the byte rate, one slot per cycle
// - error flag low marks bad block or no signal, select bit 7
// - error flag polarity can be inverted by configuration
// - interrupt pin held low while any unmasked interrupt stays active
// - interrupt pin may instead take an external stream clock
// - sleep stops the stream logic; converter power-down separate
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
module tsop_top (
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic RESET_N_I,
	input wire logic SLEEP_I,
	input wire logic [tsop_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	input wire logic [7:0] PKT_DATA_I,
	input wire logic PKT_START_I,
	input wire logic PKT_VALID_I,
	output logic PKT_READY_O,
	input wire logic BLK_UNCORR_I,
	input wire logic NO_SIGNAL_I,
	output logic [7:0] STREAM_BYTE_BUS_O,
	output logic PACKET_START_FLAG_O,
	output logic BYTE_VALID_FLAG_O,
	output logic STREAM_BYTE_CLOCK_O,
	output logic BLOCK_ERROR_FLAG_O,
	output logic STREAM_OE_O,
	input wire logic IRQ_N_I,
	output logic IRQ_N_O,
	output logic IRQ_N_OE_O,
	output logic ADC_PD_O
);
	logic [1:0] rpin_q;
	logic rst;
	logic [1:0] sleep_q;
	logic asleep;
	logic ack_q;
	logic req;
	logic wr;
	logic [31:0] rdata_q;
	logic [7:0] ctrl_q;
	logic [7:0] monitor_control_q;
	logic [7:0] pkt_cnt_q;
	logic [7:0] data_q;
	logic start_q;
	logic valid_q;
	logic take;
	logic uncorr_q;
	logic nosig_q;
	logic err_active;
	logic err_flag_q;
	logic [tsop_pkg::EV_W-1:0] ev;
	logic [tsop_pkg::EV_W-1:0] clr;
	logic [tsop_pkg::EV_W-1:0] irq_status;
	logic [tsop_pkg::EV_W-1:0] irq_mask;
	logic irq;
	logic clk_in_sel;

	// ----------------------------------------
	// reset pin and sleep pin
	// ----------------------------------------
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			rpin_q <= 2'h0;
		end else begin
			rpin_q <= {rpin_q[0], RESET_N_I};
		end
	end

	assign rst = RST_I | ~rpin_q[1];

	always_ff @(posedge MCLK_I or posedge rst) begin
		if (rst) begin
			sleep_q <= 2'h0;
		end else begin
			sleep_q <= {sleep_q[0], SLEEP_I};
		end
	end
	assign asleep = sleep_q[1];

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	// one wait cycle; read data are built while waitrequest is high
	assign req = AVS_READ_I | AVS_WRITE_I;
	assign AVS_WAITREQUEST_O = req & ~ack_q;
	assign wr = AVS_WRITE_I & ack_q & AVS_BYTEENABLE_I[0];

	always_ff @(posedge MCLK_I or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	always_ff @(posedge MCLK_I or posedge rst) begin
		if (rst) begin
			rdata_q <= 32'h0;
		end else if (AVS_READ_I && !ack_q) begin
			rdata_q <= 32'h0;
			unique case (AVS_ADDRESS_I)
				tsop_pkg::REG_CTRL: begin
					rdata_q[7:0] <= ctrl_q;
				end
				tsop_pkg::REG_MONITOR_CONTROL: begin
					rdata_q[7:0] <= monitor_control_q;
				end
				tsop_pkg::REG_IRQ_STATUS: begin
					rdata_q[tsop_pkg::EV_W-1:0] <= irq_status;
				end
				tsop_pkg::REG_IRQ_MASK: begin
					rdata_q[tsop_pkg::EV_W-1:0] <= irq_mask;
				end
				tsop_pkg::REG_STREAM_STATUS: begin
					rdata_q[15:0] <= {pkt_cnt_q, 4'h0, clk_in_sel,
						uncorr_q, NO_SIGNAL_I, asleep};
				end
				default: begin
					rdata_q <= 32'h0;
				end
			endcase
		end
	end
	assign AVS_READDATA_O = rdata_q;

	always_ff @(posedge MCLK_I or posedge rst) begin
		if (rst) begin
			ctrl_q <= tsop_pkg::CTRL_RST;
		end else if (wr && AVS_ADDRESS_I == tsop_pkg::REG_CTRL) begin
			ctrl_q <= AVS_WRITEDATA_I[7:0];
		end
	end

	always_ff @(posedge MCLK_I or posedge rst) begin
		if (rst) begin
			monitor_control_q <= tsop_pkg::MON_RST;
		end else if (wr && AVS_ADDRESS_I == tsop_pkg::REG_MONITOR_CONTROL) begin
			monitor_control_q <= AVS_WRITEDATA_I[7:0];
		end
	end

	// converter power-down stays a register bit
	assign ADC_PD_O = ctrl_q[tsop_pkg::CTRL_ADC_PD];
	assign clk_in_sel = ctrl_q[tsop_pkg::CTRL_CLK_IN_SEL];

	// ----------------------------------------
	// byte slot timing
	// ----------------------------------------
	tsop_slot_if slot (.clk(MCLK_I), .rst(rst));

	assign slot.run = ctrl_q[tsop_pkg::CTRL_STREAM_EN] & ~asleep;
	// interrupt pin becomes the stream clock input
	assign slot.ext_sel = clk_in_sel;

	tsop_slot_gen #(.HALF(tsop_pkg::BCLK_HALF_CYC)) u_slot (
		.s(slot.gen),
		.link_clk_i(IRQ_N_I)
	);

	assign STREAM_BYTE_CLOCK_O = slot.bclk;

	// ----------------------------------------
	// byte output
	// ----------------------------------------
	// bytes are taken only as the byte clock falls
	assign PKT_READY_O = slot.fall;
	assign take = slot.fall & PKT_VALID_I;

	always_ff @(posedge MCLK_I or posedge rst) begin
		if (rst) begin
			data_q <= 8'h00;
		end else if (take) begin
			data_q <= PKT_DATA_I;
		end
	end

	// valid only for a slot that carries a byte
	always_ff @(posedge MCLK_I or posedge rst) begin
		if (rst) begin
			valid_q <= 1'b0;
		end else if (slot.fall) begin
			valid_q <= PKT_VALID_I;
		end else if (!slot.run) begin
			valid_q <= 1'b0;
		end
	end

	// start marks the first byte only
	always_ff @(posedge MCLK_I or posedge rst) begin
		if (rst) begin
			start_q <= 1'b0;
		end else if (slot.fall) begin
			start_q <= take & PKT_START_I;
		end else if (!slot.run) begin
			start_q <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_I or posedge rst) begin
		if (rst) begin
			pkt_cnt_q <= 8'h00;
		end else if (take && PKT_START_I) begin
			pkt_cnt_q <= pkt_cnt_q + 8'h01;
		end
	end

	assign STREAM_BYTE_BUS_O = data_q;
	assign PACKET_START_FLAG_O = start_q;
	assign BYTE_VALID_FLAG_O = valid_q;
	// one disable bit for the bus
	// flags and clock follow the bus
	assign STREAM_OE_O = ~ctrl_q[tsop_pkg::CTRL_OUT_DIS];

	// ----------------------------------------
	// block error flag
	// ----------------------------------------
	// bad block indication lasts until the next packet begins
	always_ff @(posedge MCLK_I or posedge rst) begin
		if (rst) begin
			uncorr_q <= 1'b0;
		end else if (BLK_UNCORR_I) begin
			uncorr_q <= 1'b1;
		end else if (take && PKT_START_I) begin
			uncorr_q <= 1'b0;
		end
	end

	assign err_active = monitor_control_q[tsop_pkg::MON_ERROR_INDICATOR_SELECT]
		? NO_SIGNAL_I : uncorr_q;

	// optional inversion of the active low flag
	always_ff @(posedge MCLK_I or posedge rst) begin
		if (rst) begin
			err_flag_q <= 1'b1;
		end else begin
			err_flag_q <= ~err_active ^ ctrl_q[tsop_pkg::CTRL_ERR_INV];
		end
	end
	assign BLOCK_ERROR_FLAG_O = err_flag_q;

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	always_ff @(posedge MCLK_I or posedge rst) begin
		if (rst) begin
			nosig_q <= 1'b0;
		end else begin
			nosig_q <= NO_SIGNAL_I;
		end
	end

	assign ev = {take & PKT_START_I, NO_SIGNAL_I & ~nosig_q, BLK_UNCORR_I};
	assign clr = (wr && AVS_ADDRESS_I == tsop_pkg::REG_IRQ_STATUS)
		? AVS_WRITEDATA_I[tsop_pkg::EV_W-1:0] : '0;

	tsop_irq #(.W(tsop_pkg::EV_W)) u_irq (
		.clk_i(MCLK_I),
		.rst_i(rst),
		.ev_i(ev),
		.clr_i(clr),
		.mask_we_i(wr && AVS_ADDRESS_I == tsop_pkg::REG_IRQ_MASK),
		.mask_d_i(AVS_WRITEDATA_I[tsop_pkg::EV_W-1:0]),
		.status_o(irq_status),
		.mask_o(irq_mask),
		.irq_o(irq)
	);

	// open drain, pulled low while active
	// never driven while used as a clock input
	assign IRQ_N_O = 1'b0;
	assign IRQ_N_OE_O = irq & ~clk_in_sel;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_PIN_RESET: assert property (@(posedge MCLK_I) disable iff (RST_I)
		!rpin_q[1] |=> !BYTE_VALID_FLAG_O && !PKT_READY_O)
		else $error("pin reset did not hold stream");
	AST_START_FIRST: assert property (@(posedge MCLK_I) disable iff (rst)
		take && PKT_START_I |=> PACKET_START_FLAG_O)
		else $error("start flag missing on first byte");
	AST_START_VALID: assert property (@(posedge MCLK_I) disable iff (rst)
		PACKET_START_FLAG_O |-> BYTE_VALID_FLAG_O)
		else $error("start flag on an empty slot");
	AST_VALID_SLOT: assert property (@(posedge MCLK_I) disable iff (rst)
		slot.fall && !PKT_VALID_I |=> !BYTE_VALID_FLAG_O)
		else $error("valid flag without a byte");
	AST_BUS_DISABLE: assert property (@(posedge MCLK_I) disable iff (rst)
		wr && AVS_ADDRESS_I == tsop_pkg::REG_CTRL && AVS_WRITEDATA_I[0]
		|=> !STREAM_OE_O)
		else $error("outputs not tri-stated");
	AST_ERR_NOSIG: assert property (@(posedge MCLK_I) disable iff (rst)
		monitor_control_q[7] && NO_SIGNAL_I && !ctrl_q[1]
		|=> !BLOCK_ERROR_FLAG_O)
		else $error("no signal not flagged");
	AST_ERR_INVERT: assert property (@(posedge MCLK_I) disable iff (rst)
		!monitor_control_q[7] && uncorr_q && ctrl_q[1]
		|=> BLOCK_ERROR_FLAG_O)
		else $error("inverted flag wrong");
	AST_IRQ_HOLD: assert property (@(posedge MCLK_I) disable iff (rst)
		|(ev & irq_mask) && !clk_in_sel ##1 !clk_in_sel
		|-> IRQ_N_OE_O)
		else $error("interrupt pin not pulled low");
	AST_CLK_IN: assert property (@(posedge MCLK_I) disable iff (rst)
		clk_in_sel |-> !IRQ_N_OE_O)
		else $error("clock input pin driven");
	AST_SLEEP: assert property (@(posedge MCLK_I) disable iff (rst)
		asleep [*2] |-> !PKT_READY_O && !STREAM_BYTE_CLOCK_O)
		else $error("stream runs in sleep");
	AST_EDGE: assert property (@(posedge MCLK_I) disable iff (rst)
		!slot.fall |=> $stable(STREAM_BYTE_BUS_O))
		else $error("bus moved off the falling edge");
	COV_START: cover property (@(posedge MCLK_I) disable iff (rst)
		PACKET_START_FLAG_O ##1 !PACKET_START_FLAG_O);
	COV_ERR: cover property (@(posedge MCLK_I) disable iff (rst)
		$fell(BLOCK_ERROR_FLAG_O));
	COV_IRQ: cover property (@(posedge MCLK_I) disable iff (rst)
		$rose(IRQ_N_OE_O));
endmodule

/* tsop_pkg.sv */
package tsop_pkg;
	// ----------------------------------------
	// register word indices
	// ----------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_MONITOR_CONTROL = 4'h1;
	localparam logic [3:0] REG_IRQ_STATUS = 4'h2;
	localparam logic [3:0] REG_IRQ_MASK = 4'h3;
	localparam logic [3:0] REG_STREAM_STATUS = 4'h4;
	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int CTRL_OUT_DIS = 0;
	localparam int CTRL_ERR_INV = 1;
	localparam int CTRL_CLK_IN_SEL = 2;
	localparam int CTRL_ADC_PD = 3;
	localparam int CTRL_STREAM_EN = 4;
	localparam logic [7:0] CTRL_RST = 8'h10;
	localparam int MON_ERROR_INDICATOR_SELECT = 7;
	localparam logic [7:0] MON_RST = 8'h00;
	localparam int EV_UNCORR = 0;
	localparam int EV_NO_SIGNAL = 1;
	localparam int EV_PKT_START = 2;
	localparam int EV_W = 3;
	localparam logic [EV_W-1:0] MASK_RST = 3'h0;
	// ----------------------------------------
	// byte slot timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int BCLK_PERIOD_NS = 400;
	localparam int BCLK_HALF_CYC = BCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

/* tsop_slot_if.sv */
interface tsop_slot_if (
	input wire logic clk,
	input wire logic rst
);
	logic run;
	logic ext_sel;
	logic rise;
	logic fall;
	logic bclk;
	modport gen (input clk, input rst, input run, input ext_sel,
		output rise, output fall, output bclk);
	modport sink (input clk, input rst, output run, output ext_sel,
		input rise, input fall, input bclk);
endinterface

/* tsop_slot_gen.sv */
module tsop_slot_gen #(
	parameter int HALF = tsop_pkg::BCLK_HALF_CYC
) (
	tsop_slot_if.gen s,
	input wire logic link_clk_i
);
	localparam int CW = $clog2(HALF) + 1;
	logic [1:0] lsync_q;
	logic [CW-1:0] cnt_q;
	logic bclk_q;
	logic bclk_d;
	logic tog;

	// ----------------------------------------
	// link clock sampling
	// ----------------------------------------
	always_ff @(posedge s.clk or posedge s.rst) begin
		if (s.rst) begin
			lsync_q <= 2'h0;
		end else begin
			lsync_q <= {lsync_q[0], link_clk_i};
		end
	end

	always_ff @(posedge s.clk or posedge s.rst) begin
		if (s.rst) begin
			cnt_q <= '0;
		end else if (!s.run || s.ext_sel || tog) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

	assign tog = s.run && !s.ext_sel && (cnt_q == CW'(HALF - 1));
	always_comb begin
		bclk_d = bclk_q;
		if (!s.run) begin
			bclk_d = 1'b0;
		end else if (s.ext_sel) begin
			bclk_d = lsync_q[1];
		end else if (tog) begin
			bclk_d = ~bclk_q;
		end
	end

	always_ff @(posedge s.clk or posedge s.rst) begin
		if (s.rst) begin
			bclk_q <= 1'b0;
		end else begin
			bclk_q <= bclk_d;
		end
	end

	// pulses lead the clock flop by one edge so data moves with it
	assign s.rise = bclk_d & ~bclk_q;
	assign s.fall = bclk_q & ~bclk_d;
	assign s.bclk = bclk_q;

	// sleep, disable or a switch to the pin clock may cut a phase short
	AST_BCLK_HALF: assert property (@(posedge s.clk) disable iff (s.rst)
		s.run && !s.ext_sel && s.rise
		|=> (!s.fall || !s.run || s.ext_sel) [*3])
		else $error("byte clock high phase too short");
endmodule

/* tsop_irq.sv */
module tsop_irq #(
	parameter int W = tsop_pkg::EV_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] ev_i,
	input wire logic [W-1:0] clr_i,
	input wire logic mask_we_i,
	input wire logic [W-1:0] mask_d_i,
	output logic [W-1:0] status_o,
	output logic [W-1:0] mask_o,
	output logic irq_o
);
	logic [W-1:0] status_q;
	logic [W-1:0] mask_q;

	// set wins over a clear in the same cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			status_q <= '0;
		end else begin
			status_q <= (status_q & ~clr_i) | ev_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mask_q <= tsop_pkg::MASK_RST;
		end else if (mask_we_i) begin
			mask_q <= mask_d_i;
		end
	end

	assign status_o = status_q;
	assign mask_o = mask_q;
	assign irq_o = |(status_q & mask_q);

	AST_SET_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
		|(ev_i & clr_i) |=> |(status_q & $past(ev_i)))
		else $error("event lost against clear");
endmodule

/* tsop_rx_model.sv */
module tsop_rx_model (
	input wire logic bclk_i,
	input wire logic oe_i,
	input wire logic valid_i,
	input wire logic start_i,
	input wire logic [7:0] data_i,
	output int n_o,
	output logic [8:0] last_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		n_o = 0;
		last_o = 9'h000;
	end
	// ----------------------------------------
	// receiver capture
	// ----------------------------------------
	// rising edge capture
	// sampled on the edge opposite the launch, so no hold race on the bus
	always @(posedge bclk_i) begin
		if (oe_i === 1'b1 && valid_i === 1'b1) begin
			last_o <= {start_i, data_i};
			n_o <= n_o + 1;
		end
	end
endmodule

/* tsop_top_bench.sv */
module tsop_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0, rst = 1'b1, reset_n = 1'b1, sleep = 1'b0;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0, wr = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, r;
	logic [7:0] pdata = 8'h00, bus;
	logic pstart = 1'b0, pvalid = 1'b0, uncorr = 1'b0, nosig = 1'b0;
	logic link_clk = 1'b0, ext_run = 1'b0, ext_mode = 1'b0;
	logic wait_r, ready, sbc, pst, bvf, bef, oe, irq_o, irq_oe, adc_pd, acc;
	logic [8:0] rx_last;
	int num_errors = 0, checks = 0, n_rx, cnt;
	// open-drain pin with pull-up, or the external stream clock
	wire irq_pin = ext_mode ? link_clk : (irq_oe ? irq_o : 1'b1);
	// no test pin reaches the byte enables; the system holds them all high
	tsop_top DUT (.MCLK_I(mclk), .RST_I(rst), .RESET_N_I(reset_n),
		.SLEEP_I(sleep), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
		.AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata),
		.AVS_WAITREQUEST_O(wait_r), .PKT_DATA_I(pdata),
		.PKT_START_I(pstart), .PKT_VALID_I(pvalid), .PKT_READY_O(ready),
		.BLK_UNCORR_I(uncorr), .NO_SIGNAL_I(nosig),
		.STREAM_BYTE_BUS_O(bus), .PACKET_START_FLAG_O(pst),
		.BYTE_VALID_FLAG_O(bvf), .STREAM_BYTE_CLOCK_O(sbc),
		.BLOCK_ERROR_FLAG_O(bef), .STREAM_OE_O(oe), .IRQ_N_I(irq_pin),
		.IRQ_N_O(irq_o), .IRQ_N_OE_O(irq_oe), .ADC_PD_O(adc_pd));
	tsop_rx_model rx (.bclk_i(sbc), .oe_i(oe), .valid_i(bvf),
		.start_i(pst), .data_i(bus), .n_o(n_rx), .last_o(rx_last));
	// ----------------------------------------
	// clocks and watchdog
	// ----------------------------------------
	initial begin
		forever #25 mclk = ~mclk;
	end
	// slow link clock, only while frames run
	initial begin
		#7;
		forever begin
			#200;
			if (ext_run) link_clk = ~link_clk;
		end
	end
	initial begin
		#2000000;
		num_errors++;
		finish_test();
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic finish_test();
		$display("errors=%0d checks=%0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// held until waitrequest is sampled low at a rising edge, then released
	task automatic bus_op(input logic w, input logic [3:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= {24'h0, d};
		do begin
			@(posedge mclk);
			n++;
		end while (wait_r !== 1'b0 && n < 50);
		if (n >= 50) num_errors++;
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		wdata <= ~{24'h0, d};
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		bus_op(1'b0, a, 8'h00);
		check(r, {24'h0, e});
	endtask
	task automatic send(input logic [7:0] d, input logic s);
		int n, c0;
		n = 0;
		c0 = n_rx;
		@(posedge mclk);
		pdata <= d;
		pstart <= s;
		pvalid <= 1'b1;
		do begin
			@(negedge mclk);
			n++;
		end while (ready !== 1'b1 && n < 200);
		if (n >= 200) num_errors++;
		@(posedge mclk);
		pvalid <= 1'b0;
		pstart <= 1'b0;
		pdata <= ~d;
		n = 0;
		while (n_rx == c0 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 200) num_errors++;
		check({23'h0, rx_last}, {23'h0, s, d});
	endtask
	task automatic pulse_uncorr();
		@(posedge mclk);
		uncorr <= 1'b1;
		@(posedge mclk);
		uncorr <= 1'b0;
	endtask
	function automatic logic exp_err(logic sel, logic inv, logic u, logic ns);
		logic a;
		a = sel ? ns : u;
		return inv ? a : !a;
	endfunction
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(46693));
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		cyc(2);
		check({31'h0, oe}, 32'h1);
		check({31'h0, irq_oe}, 32'h0);
		rd_chk(tsop_pkg::REG_CTRL, tsop_pkg::CTRL_RST);
		rd_chk(tsop_pkg::REG_MONITOR_CONTROL, tsop_pkg::MON_RST);
		rd_chk(tsop_pkg::REG_IRQ_MASK, 8'h00);
		rd_chk(4'hF, 8'h00);
		for (int p = 0; p < 3; p++) begin
			for (int b = 0; b < 4; b++) begin
				send(8'($urandom()), b == 0);
			end
		end
		cnt = 0;
		do @(negedge mclk); while (sbc !== 1'b0);
		do @(negedge mclk); while (sbc !== 1'b1);
		// one full period: through the high phase, the low phase and back to high
		do begin
			@(negedge mclk);
			cnt++;
		end while (sbc !== 1'b0 && cnt < 50);
		do begin
			@(negedge mclk);
			cnt++;
		end while (sbc !== 1'b1 && cnt < 50);
		check(cnt, 2 * tsop_pkg::BCLK_HALF_CYC);
		bus_op(1'b1, tsop_pkg::REG_CTRL, 8'h11);
		cyc(3);
		check({31'h0, oe}, 32'h0);
		// bad block stays latched through the loop: no packet start follows
		pulse_uncorr();
		for (int i = 0; i < 4; i++) begin
			bus_op(1'b1, tsop_pkg::REG_MONITOR_CONTROL, {i[0], 7'h00});
			bus_op(1'b1, tsop_pkg::REG_CTRL, {6'h04, i[1], 1'b0});
			@(posedge mclk);
			nosig <= 1'b1;
			cyc(3);
			check({31'h0, bef}, {31'h0, exp_err(i[0], i[1], 1, 1)});
			@(posedge mclk);
			nosig <= 1'b0;
			cyc(3);
			check({31'h0, bef}, {31'h0, exp_err(i[0], i[1], 1, 0)});
		end
		bus_op(1'b1, tsop_pkg::REG_MONITOR_CONTROL, 8'h00);
		bus_op(1'b1, tsop_pkg::REG_CTRL, tsop_pkg::CTRL_RST);
		bus_op(1'b1, tsop_pkg::REG_IRQ_STATUS, 8'h07);
		bus_op(1'b1, tsop_pkg::REG_IRQ_MASK, 8'h01);
		pulse_uncorr();
		cyc(3);
		check({31'h0, bef}, 32'h0);
		check({31'h0, irq_pin}, 32'h0);
		rd_chk(tsop_pkg::REG_IRQ_STATUS, 8'h01);
		bus_op(1'b1, tsop_pkg::REG_IRQ_MASK, 8'h00);
		cyc(2);
		check({31'h0, irq_pin}, 32'h1);
		bus_op(1'b1, tsop_pkg::REG_IRQ_MASK, 8'h01);
		cyc(2);
		check({31'h0, irq_pin}, 32'h0);
		send(8'hA5, 1'b1);
		cyc(3);
		check({31'h0, bef}, 32'h1);
		bus_op(1'b1, tsop_pkg::REG_IRQ_STATUS, 8'h01);
		cyc(2);
		check({31'h0, irq_pin}, 32'h1);
		pulse_uncorr();
		bus_op(1'b1, tsop_pkg::REG_CTRL, 8'h14);
		ext_mode <= 1'b1;
		cyc(3);
		check({31'h0, irq_oe}, 32'h0);
		ext_run = 1'b1;
		send(8'($urandom()), 1'b1);
		send(8'($urandom()), 1'b0);
		ext_run = 1'b0;
		bus_op(1'b1, tsop_pkg::REG_CTRL, tsop_pkg::CTRL_RST);
		ext_mode <= 1'b0;
		bus_op(1'b1, tsop_pkg::REG_IRQ_STATUS, 8'h07);
		@(posedge mclk);
		sleep <= 1'b1;
		pvalid <= 1'b1;
		cyc(6);
		acc = 1'b0;
		repeat (20) begin
			@(negedge mclk);
			acc = acc | sbc | ready | bvf;
		end
		check({31'h0, acc}, 32'h0);
		// five packet starts sent so far; asleep, no bad block pending
		bus_op(1'b0, tsop_pkg::REG_STREAM_STATUS, 8'h00);
		check(r, 32'h0000_0501);
		bus_op(1'b1, tsop_pkg::REG_CTRL, 8'h18);
		cyc(2);
		check({31'h0, adc_pd}, 32'h1);
		@(posedge mclk);
		sleep <= 1'b0;
		pvalid <= 1'b0;
		@(posedge mclk);
		reset_n <= 1'b0;
		cyc(4);
		check({31'h0, adc_pd}, 32'h0);
		check({31'h0, irq_oe}, 32'h0);
		@(posedge mclk);
		reset_n <= 1'b1;
		cyc(4);
		rd_chk(tsop_pkg::REG_CTRL, tsop_pkg::CTRL_RST);
		finish_test();
	end
endmodule
